// file: bgdce_cfg.svh
/*
  Constants of the background debug command engine: opcodes, field
  positions, addresses and cycle counts. Assumes one 50 MHz clock that
  serves as the E clock.
*/
`ifndef BGDCE_CFG_SVH
`define BGDCE_CFG_SVH
// ============================================================
// Opcodes and opcode fields
`define BGDCE_OP_CPU_BREAK_INSTRUCTION 8'h90
`define BGDCE_FW_RD_LO 8'h62
`define BGDCE_FW_RD_HI 8'h67
`define BGDCE_FW_WR_LO 8'h42
`define BGDCE_FW_WR_HI 8'h47
`define BGDCE_FW_GO 8'h08
`define BGDCE_FW_TRACE 8'h10
`define BGDCE_FW_ARM_TAGS_RESUME 8'h18
`define BGDCE_B_RD 5
`define BGDCE_B_WORD 3
`define BGDCE_B_MAP 2
// ============================================================
// Addresses and reset values
`define BGDCE_ADR_STATUS 16'hFF01
`define BGDCE_STAT_RST 8'h00
// ============================================================
// Cycle counts and FIFO depth
`define BGDCE_SAMPLE 5'h0A
`define BGDCE_TX1_PULSE 5'h07
`define BGDCE_TX0_LOW 5'h0D
`define BGDCE_TIMEOUT 10'h200
`define BGDCE_STEAL 8'h80
`define BGDCE_FIFO_DEPTH 16
`endif

// file: bgdce_pkg.sv
/*
  Types of the background debug command engine.
  Assumes bgdce_cfg.svh for all numeric constants.
*/
package bgdce_pkg;
  // ============================================================
  // Command sequencer states
  typedef enum logic [4:0] {
    ST_OPC = 5'h01,
    ST_ARG = 5'h02,
    ST_MEM = 5'h04,
    ST_FW = 5'h08,
    ST_TX = 5'h10
  } bgdce_state_t;
endpackage

// file: bgdce_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a flush.
  Assumes one clock; the reader may stall at will.
*/
`include "bgdce_cfg.svh"
module bgdce_fifo
  import bgdce_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // async reset
  input wire logic flush, // empty the buffer
  input wire logic inValid, // write request
  output logic inReady, // space free
  input wire logic [WIDTH-1:0] inData, // write data
  output logic outValid, // data present
  input wire logic outReady, // reader takes
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic full;
  logic empty;
  assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty = wrPtr == rdPtr;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr[AW-1:0]];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else if (flush) begin
      rdPtr <= wrPtr;
    end else begin
      if (inValid && !full) wrPtr <= wrPtr + 1'b1;
      if (outReady && !empty) rdPtr <= rdPtr + 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (inValid && !full) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule

// file: bgdce_serial.sv
/*
  Bit engine of the single-wire debug link: edge detect, receive,
  transmit and link timeout. Assumes the host starts every bit with a
  falling edge; the pin wire is resolved outside from pinOe.
*/
`include "bgdce_cfg.svh"
module bgdce_serial
  import bgdce_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rst_n, // async reset
  input wire logic pinIn, // wire level
  output logic pinOut, // driven level
  output logic pinOe, // drive enable
  output logic [7:0] rxByte, // received byte
  output logic rxValid, // byte waiting
  input wire logic rxReady, // byte taken
  input wire logic [15:0] txWord, // word to send
  input wire logic txLoad, // start sending
  output logic txBusy, // sending
  output logic linkTimeout // no edge for long
);
  logic pinMeta;
  logic pinSync;
  logic pinPrev;
  logic fall;
  logic [4:0] phase;
  logic [2:0] rxCnt;
  logic [7:0] rxShift;
  logic [15:0] txShift;
  logic [3:0] txCnt;
  logic [9:0] idleCnt;
  assign fall = pinPrev & ~pinSync;
  // ============================================================
  // Synchroniser and bit phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
      pinPrev <= 1'b1;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end
  // Saturates so each bit is sampled only once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) phase <= '1;
    else if (fall) phase <= '0;
    else if (phase != '1) phase <= phase + 5'h01;
  end
  // ============================================================
  // Receive, most significant bit first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCnt <= '0;
      rxShift <= '0;
      rxByte <= '0;
      rxValid <= 1'b0;
    end else begin
      if (rxValid && rxReady) rxValid <= 1'b0;
      if (linkTimeout) begin
        rxCnt <= '0;
      end else if (phase == `BGDCE_SAMPLE && !txBusy) begin // RULE23
        rxShift <= {rxShift[6:0], pinSync};
        rxCnt <= rxCnt + 3'h1;
        if (rxCnt == 3'h7) begin
          rxByte <= {rxShift[6:0], pinSync};
          rxValid <= 1'b1;
        end
      end
    end
  end
  // ============================================================
  // Transmit; host clocks each bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift <= '0;
      txCnt <= '0;
      txBusy <= 1'b0;
    end else if (linkTimeout) begin
      txBusy <= 1'b0;
    end else if (txLoad) begin
      txShift <= txWord;
      txCnt <= '0;
      txBusy <= 1'b1;
    end else if (txBusy && phase == `BGDCE_TX0_LOW) begin
      txShift <= {txShift[14:0], 1'b0};
      txCnt <= txCnt + 4'h1;
      if (txCnt == 4'hF) txBusy <= 1'b0;
    end
  end
  // Short high pulse speeds up the rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOe <= 1'b0;
      pinOut <= 1'b0;
    end else begin
      pinOe <= 1'b0;
      pinOut <= 1'b0;
      if (txBusy) begin
        if (!txShift[15] && phase < `BGDCE_TX0_LOW) begin
          pinOe <= 1'b1;
        end else if (!txShift[15] && phase == `BGDCE_TX0_LOW) begin
          pinOe <= 1'b1;
          pinOut <= 1'b1;
        end else if (txShift[15] && phase == `BGDCE_TX1_PULSE) begin
          pinOe <= 1'b1;
          pinOut <= 1'b1;
        end
      end
    end
  end
  // ============================================================
  // Timeout, one pulse per quiet spell
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt <= `BGDCE_TIMEOUT;
      linkTimeout <= 1'b0;
    end else begin
      linkTimeout <= idleCnt == `BGDCE_TIMEOUT - 10'h001; // RULE24
      if (fall) idleCnt <= '0;
      else if (idleCnt != `BGDCE_TIMEOUT) idleCnt <= idleCnt + 10'h001;
    end
  end
endmodule

// file: bgdce_engine.sv
/*
  Background debug command engine: opcode decode, hardware memory
  access with cycle stealing, firmware command hand-off to the CPU and
  background mode control. Assumes CPU-side inputs are on sys_clk and
  the debug wire and mode strap are asynchronous pins.
*/
// Notes on behaviour
// [RULE1] No background entry while firmware disabled
// [RULE2] Byte write to status sets enable
// [RULE3] Active mode maps debug area at top
// [RULE4] Enter via command, tag hit or break
// [RULE5] Command waits boundary; tag enters before execution
// [RULE6] Special single-chip reset starts enabled and active
// [RULE7] Suspend-enabled peripherals halt while active
// [RULE8] Opcode byte, then address and/or data
// [RULE9] Hardware commands run in any mode
// [RULE10] Host waits 150 cycles between phases
// [RULE11] Wait for idle cycle, steal after 128
// [RULE12] Multi-cycle accesses freeze the CPU
// [RULE13] Opcode 90 enters background if enabled
// [RULE14] Read opcodes E0 E4 E8 EC
// [RULE15] Write opcodes C0 C4 C8 CC
// [RULE16] Odd byte low, even high; words aligned
// [RULE17] Status reads 00, 80 or C0; code also shows tagEn in bit 5 and traceMode in bit 3 (A0, 88)
// [RULE18] Host sets enable by read-modify-write
// [RULE19] Firmware commands only while active
// [RULE20] Firmware reads 62 to 67
// [RULE21] Firmware writes 42 to 47
// [RULE22] Go, single step, arm tags and go
// [RULE23] Bits MSB first, host falling edge
// [RULE24] Quiet link clears the command register
// [RULE25] Unknown or gated opcodes do nothing
`include "bgdce_cfg.svh"
module bgdce_engine
  import bgdce_pkg::*;
(
  input wire logic sys_clk, // clock, E rate
  input wire logic rst_n, // async reset
  input wire logic dbgPinIn, // debug wire level
  output logic dbgPinOut, // debug wire drive level
  output logic dbgPinOe, // debug wire drive enable
  input wire logic modeSpecialSc, // special single-chip strap
  input wire logic cpuIdle, // free bus cycle
  input wire logic instrBoundary, // instruction completed
  input wire logic tagHit, // tagged instruction next
  input wire logic breakInstr, // break instruction run
  output logic cpuFreeze, // stop CPU clocks
  output logic cpuResume, // return to user code
  output logic bgActive, // background mode
  output logic dbgMapped, // debug area overlaid
  output logic fwStrobe, // firmware command start
  output logic [7:0] fwOp, // firmware opcode
  output logic [15:0] fwWdata, // firmware write data
  input wire logic fwDone, // firmware finished
  input wire logic [15:0] fwRdata, // firmware read data
  output logic memReq, // memory access
  output logic memWrite, // access is a write
  output logic memWord, // word access
  output logic memDbgMap, // debug area in map
  output logic [15:0] memAddr, // access address
  output logic [15:0] memWdata, // write data
  input wire logic [15:0] memRdata, // read data
  input wire logic memAck, // access done
  input wire logic [3:0] suspendEn, // per-peripheral suspend
  output logic [3:0] periphHalt // peripheral halt
);
  bgdce_state_t state;
  logic [7:0] instr;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] shiftReg;
  logic [2:0] argCnt;
  logic [2:0] argNeed;
  logic txLoad;
  logic txBusy;
  logic linkTimeout;
  logic [7:0] rxByte;
  logic rxValid;
  logic rxReady;
  logic fifoValid;
  logic fifoReady;
  logic [7:0] rxOp;
  logic take;
  logic fwEn;
  logic tagEn;
  logic traceMode;
  logic enterPend;
  logic modeMeta;
  logic modeSync;
  logic [1:0] strapCnt;
  logic [7:0] statusByte;
  logic opHw;
  logic fwRead;
  logic fwWrite;
  logic goCmd;
  logic goReq;
  logic lastArg;
  logic localHit;
  logic stWrite;
  logic enterNow;
  logic grant;
  logic stole;
  logic multi;
  logic [7:0] waitCnt;

  // ============================================================
  // Link and byte buffer
  bgdce_serial uSerial (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinIn(dbgPinIn),
    .pinOut(dbgPinOut),
    .pinOe(dbgPinOe),
    .rxByte(rxByte),
    .rxValid(rxValid),
    .rxReady(rxReady),
    .txWord(shiftReg),
    .txLoad(txLoad),
    .txBusy(txBusy),
    .linkTimeout(linkTimeout)
  );

  // Bytes wait here while the sequencer is busy with an access
  bgdce_fifo #(
    .WIDTH(8),
    .DEPTH(`BGDCE_FIFO_DEPTH)
  ) uFifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(linkTimeout),
    .inValid(rxValid),
    .inReady(rxReady),
    .inData(rxByte),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(rxOp)
  );

  // ============================================================
  // Opcode decode
  assign fifoReady = state == ST_OPC || state == ST_ARG;
  assign take = fifoValid && fifoReady;
  // Field pattern admits exactly the eight read and write opcodes
  assign opHw = rxOp[7:6] == 2'h3 && !rxOp[4] && rxOp[1:0] == 2'h0; // RULE14 RULE15
  assign fwRead = rxOp >= `BGDCE_FW_RD_LO && rxOp <= `BGDCE_FW_RD_HI; // RULE20
  assign fwWrite = rxOp >= `BGDCE_FW_WR_LO && rxOp <= `BGDCE_FW_WR_HI; // RULE21
  assign goCmd = rxOp == `BGDCE_FW_GO || rxOp == `BGDCE_FW_TRACE
    || rxOp == `BGDCE_FW_ARM_TAGS_RESUME;
  assign goReq = state == ST_OPC && take && bgActive && goCmd; // RULE22
  assign lastArg = argCnt == argNeed - 3'h1;
  assign localHit = instr[`BGDCE_B_MAP] && !instr[`BGDCE_B_WORD]
    && addr == `BGDCE_ADR_STATUS;
  assign stWrite = state == ST_MEM && localHit && !instr[`BGDCE_B_RD]; // RULE2
  assign statusByte = {fwEn, bgActive, tagEn, 1'b0, traceMode, 3'h0}; // RULE17

  // ============================================================
  // Command sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OPC;
      instr <= '0;
      addr <= '0;
      wdata <= '0;
      argCnt <= '0;
      argNeed <= '0;
    end else if (linkTimeout) begin
      state <= ST_OPC; // RULE24
      instr <= '0;
    end else begin
      case (state)
        ST_OPC: begin
          if (take) begin
            instr <= rxOp; // RULE8
            argCnt <= '0;
            if (opHw) begin // RULE9
              argNeed <= rxOp[`BGDCE_B_RD] ? 3'h2 : 3'h4;
              state <= ST_ARG;
            end else if (bgActive && fwRead) begin // RULE19
              state <= ST_FW;
            end else if (bgActive && fwWrite) begin
              argNeed <= 3'h2;
              state <= ST_ARG;
            end
          end
        end
        ST_ARG: begin
          if (take) begin
            argCnt <= argCnt + 3'h1;
            if (instr[7] && argCnt < 3'h2) addr <= {addr[7:0], rxOp};
            else wdata <= {wdata[7:0], rxOp};
            if (lastArg) state <= instr[7] ? ST_MEM : ST_FW;
          end
        end
        ST_MEM: begin
          if (localHit || (grant && memAck)) begin
            state <= instr[`BGDCE_B_RD] ? ST_TX : ST_OPC;
          end
        end
        ST_FW: begin
          if (fwDone) state <= instr[`BGDCE_B_RD] ? ST_TX : ST_OPC;
        end
        ST_TX: begin
          if (!txBusy && !txLoad) state <= ST_OPC;
        end
        default: state <= ST_OPC;
      endcase
    end
  end

  // ============================================================
  // Read-back data and firmware hand-off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= '0;
      txLoad <= 1'b0;
    end else begin
      txLoad <= 1'b0;
      if (state == ST_MEM && instr[`BGDCE_B_RD] && !linkTimeout) begin
        if (localHit) begin
          shiftReg <= {8'h00, statusByte}; // RULE16 RULE17
          txLoad <= 1'b1;
        end else if (grant && memAck) begin
          shiftReg <= memRdata;
          txLoad <= 1'b1;
        end
      end else if (state == ST_FW && fwDone && instr[`BGDCE_B_RD]) begin
        shiftReg <= fwRdata;
        txLoad <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) fwStrobe <= 1'b0;
    else fwStrobe <= !linkTimeout && take && ((state == ST_OPC && bgActive && fwRead)
      || (state == ST_ARG && lastArg && !instr[7])); // RULE19 RULE25
  end
  assign fwOp = instr;
  assign fwWdata = wdata;

  // ============================================================
  // Bus access: idle cycle, else steal
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant <= 1'b0;
      stole <= 1'b0;
      multi <= 1'b0;
      waitCnt <= '0;
    end else if (state != ST_MEM || localHit || linkTimeout) begin
      grant <= 1'b0;
      stole <= 1'b0;
      multi <= 1'b0;
      waitCnt <= '0;
    end else if (!grant) begin
      if (cpuIdle || waitCnt == `BGDCE_STEAL) begin // RULE11
        grant <= 1'b1;
        stole <= !cpuIdle;
      end else begin
        waitCnt <= waitCnt + 8'h01;
      end
    end else if (memAck) begin
      grant <= 1'b0;
    end else begin
      multi <= 1'b1; // RULE12
    end
  end
  assign memReq = grant;
  // A single idle-cycle access leaves the CPU running
  assign cpuFreeze = grant && (stole || multi); // RULE12
  assign memWrite = !instr[`BGDCE_B_RD];
  assign memWord = instr[`BGDCE_B_WORD];
  assign memDbgMap = instr[`BGDCE_B_MAP]; // RULE14 RULE15
  // Misaligned word addresses are forced even
  assign memAddr = memWord ? {addr[15:1], 1'b0} : addr; // RULE16
  assign memWdata = wdata;

  // ============================================================
  // Background mode control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeMeta <= 1'b0;
      modeSync <= 1'b0;
    end else begin
      modeMeta <= modeSpecialSc;
      modeSync <= modeMeta;
    end
  end

  assign enterNow = fwEn && !bgActive && ((enterPend && instrBoundary) // RULE5
    || (tagEn && tagHit) || breakInstr || (traceMode && instrBoundary)); // RULE4

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapCnt <= '0;
      fwEn <= 1'(`BGDCE_STAT_RST >> 7);
      bgActive <= 1'b0;
      tagEn <= 1'b0;
      traceMode <= 1'b0;
      enterPend <= 1'b0;
      cpuResume <= 1'b0;
    end else begin
      cpuResume <= 1'b0;
      if (strapCnt != 2'h3) strapCnt <= strapCnt + 2'h1;
      // Strap is read once the synchroniser has settled
      if (strapCnt == 2'h2 && modeSync) begin // RULE6
        fwEn <= 1'b1;
        bgActive <= 1'b1;
      end
      if (stWrite) fwEn <= wdata[7]; // RULE2
      // Ignored while active so a stale request cannot re-enter after go
      if (state == ST_OPC && take && rxOp == `BGDCE_OP_CPU_BREAK_INSTRUCTION && fwEn && !bgActive) begin
        enterPend <= 1'b1; // RULE13
      end
      if (goReq) begin // RULE22
        bgActive <= 1'b0;
        cpuResume <= 1'b1;
        tagEn <= rxOp == `BGDCE_FW_ARM_TAGS_RESUME;
        traceMode <= rxOp == `BGDCE_FW_TRACE;
      end
      if (breakInstr && !fwEn) cpuResume <= 1'b1; // RULE1
      if (enterNow) begin // RULE1
        bgActive <= 1'b1;
        enterPend <= 1'b0;
        tagEn <= 1'b0;
        traceMode <= 1'b0;
      end
    end
  end

  assign dbgMapped = bgActive; // RULE3
  assign periphHalt = suspendEn & {4{bgActive}}; // RULE7

  // ============================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  enterNeedsEn_a: assert property ($rose(bgActive) |-> fwEn) // RULE1
    else $error("background entered with firmware disabled");
  cmdEntry_a: assert property (enterPend && fwEn && !bgActive && instrBoundary // RULE5
    |=> bgActive && !enterPend)
    else $error("pending entry missed boundary");
  tagEntry_a: assert property (tagEn && tagHit && fwEn && !bgActive // RULE4
    |=> bgActive && !tagEn)
    else $error("tag hit did not enter");
  stealBound_a: assert property ($rose(state == ST_MEM) && !localHit // RULE11
    |-> ##[0:130] memReq)
    else $error("no bus grant within steal bound");
  multiFreeze_a: assert property (memReq && !memAck |=> cpuFreeze || !memReq) // RULE12
    else $error("multi-cycle access without freeze");
  wordAlign_a: assert property (memReq && memWord |-> !memAddr[0]) // RULE16
    else $error("misaligned word access");
  statusRead_a: assert property (state == ST_MEM && localHit && instr[5] // RULE17
    |=> shiftReg[15:8] == 8'h00 && shiftReg[7] == $past(fwEn)
    && shiftReg[6] == $past(bgActive))
    else $error("status read value wrong");
  fwGate_a: assert property (fwStrobe |-> bgActive && !instr[7]) // RULE19
    else $error("firmware command while inactive");
  goExit_a: assert property (goReq |=> !bgActive && cpuResume) // RULE22
    else $error("go command did not resume");
  timeoutClr_a: assert property (linkTimeout |=> state == ST_OPC && instr == 8'h00) // RULE24
    else $error("timeout did not clear command");
  haltFollow_a: assert property ($fell(bgActive) |-> periphHalt == 4'h0) // RULE7
    else $error("peripheral still halted after exit");

  cover property (state == ST_MEM && grant && memAck && instr[5]);
  cover property (stWrite && wdata[7]);
  cover property (grant && stole);
  cover property (goReq ##[1:200] bgActive);
endmodule

// file: bgdce_host.sv
/*
  Host model of the single-wire debug link: sends bytes and words and
  clocks words back. Assumes a pull-up on the wire when nobody drives.
*/
module bgdce_host (
  input wire logic devOe, // device drives wire
  input wire logic devOut, // device level
  output logic wireLvl // resolved wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hostLow = 1'b0;
  logic hClk = 1'b0;
  // ============================================================
  // Link clock, locked to the system clock, every edge 7 ns after a system clock rising edge
  initial begin
    #37;
    forever #80 hClk = ~hClk;
  end
  assign wireLvl = devOe ? devOut : ~hostLow;
  task automatic bitTx(input logic b);
    @(posedge hClk);
    hostLow = 1'b1;
    #(b ? 60 : 310);
    hostLow = 1'b0;
    repeat (b ? 2 : 1) @(posedge hClk);
  endtask
  task automatic sendByte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bitTx(v[i]);
  endtask
  task automatic sendWord(input logic [15:0] v);
    sendByte(v[15:8]);
    sendByte(v[7:0]);
  endtask
  task automatic recvWord(output logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge hClk);
      hostLow = 1'b1;
      #60 hostLow = 1'b0;
      // Released early so the device can drive the rest of the bit
      #140 v[i] = wireLvl;
      @(posedge hClk);
    end
  endtask
endmodule

// file: bg_debug_command_engine_tb.sv
/*
  Bench of the debug command engine: host model on the wire, CPU and
  memory responders. Assumes the engine carries its own assertions.
*/
module bg_debug_command_engine_tb;
  import bgdce_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sysClk = 1'b0;
  logic rstN = 1'b0;
  logic modeSpecialSc = 1'b0;
  logic cpuIdle = 1'b1;
  logic instrBoundary = 1'b0;
  logic tagHit = 1'b0;
  logic breakInstr = 1'b0;
  logic fwDone = 1'b0;
  logic memAck = 1'b0;
  logic memHold = 1'b0;
  logic [3:0] suspendEn = 4'hA;
  logic wireLvl, pinOut, pinOe, cpuFreeze, cpuResume, bgActive, dbgMapped;
  logic fwStrobe, memReq, memWrite, memWord, memDbgMap;
  logic [7:0] fwOp;
  logic [15:0] fwWdata, memAddr, memWdata;
  logic [3:0] periphHalt;
  logic [35:0] reqInfo;
  logic [23:0] fwInfo;
  int memCount = 0;
  int fwCount = 0;
  int resCount = 0;
  int miscompares = 0;
  int comparisons = 0;
  initial begin
    forever #10 sysClk = ~sysClk;
  end
  bgdce_engine i_dut (
    .sys_clk(sysClk), .rst_n(rstN), .dbgPinIn(wireLvl), .dbgPinOut(pinOut),
    .dbgPinOe(pinOe), .modeSpecialSc(modeSpecialSc), .cpuIdle(cpuIdle),
    .instrBoundary(instrBoundary), .tagHit(tagHit), .breakInstr(breakInstr),
    .cpuFreeze(cpuFreeze), .cpuResume(cpuResume), .bgActive(bgActive),
    .dbgMapped(dbgMapped), .fwStrobe(fwStrobe), .fwOp(fwOp), .fwWdata(fwWdata),
    .fwDone(fwDone), .fwRdata({fwOp, 8'h5A}), .memReq(memReq), .memWrite(memWrite),
    .memWord(memWord), .memDbgMap(memDbgMap), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(~memAddr), .memAck(memAck),
    .suspendEn(suspendEn), .periphHalt(periphHalt)
  );
  bgdce_host i_host (.devOe(pinOe), .devOut(pinOut), .wireLvl(wireLvl));
  // ============================================================
  // CPU and memory responders; word accesses take two cycles
  // so that the freeze path of a multi-cycle access is exercised
  always @(negedge sysClk) begin
    memAck <= memReq & ~memAck & (~memWord | memHold);
    memHold <= memReq & ~memAck & ~memHold;
    fwDone <= fwStrobe;
  end
  always @(posedge sysClk) begin
    if (memReq && memAck) begin
      memCount++;
      reqInfo <= {memWrite, memWord, memDbgMap, cpuFreeze, memAddr, memWdata};
    end
    if (fwStrobe) begin
      fwCount++;
      fwInfo <= {fwOp, fwWdata};
    end
    if (cpuResume) resCount++;
  end
  // ============================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sysClk);
  endtask
  task automatic ev(input int k);
    {breakInstr, tagHit, instrBoundary} = 3'(1 << k);
    cyc(1);
    {breakInstr, tagHit, instrBoundary} = 3'b000;
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.sendByte(op);
    cyc(80);
  endtask
  task automatic rdMem(input logic [7:0] op, input logic [15:0] a, output logic [15:0] w);
    i_host.sendByte(op);
    i_host.sendWord(a);
    cyc(160);
    i_host.recvWord(w);
  endtask
  task automatic wrMem(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
    i_host.sendByte(op);
    i_host.sendWord(a);
    i_host.sendWord(d);
    cyc(160);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic tGated;
    logic [15:0] w;
    rdMem(8'hE4, 16'hFF01, w);
    chk("status", 16'h0000, w);
    cmd(8'h90);
    ev(0);
    chk("bgActive", 1'b0, bgActive);
    ev(2);
    chk("cpuResume", 1'b1, cpuResume);
    $display("Test gated finished");
  endtask
  task automatic tHwMem;
    logic [15:0] w;
    logic [7:0] op;
    for (int k = 0; k < 4; k++) begin
      op = 8'hE0 + 8'(4 * k);
      cpuIdle = (k != 2);
      rdMem(op, 16'h1235, w);
      chk("rdata", op[3] ? 8'hCB : 8'hCA, w[7:0]);
      chk("raddr", {15'h091A, ~op[3]}, reqInfo[31:16]);
      chk("rkind", {1'b0, op[3], op[2], (k == 2) || op[3]}, reqInfo[35:32]);
      op = 8'hC0 + 8'(4 * k);
      wrMem(op, 16'h2001, 16'hA55A);
      chk("waddr", {15'h1000, ~op[3]}, reqInfo[31:16]);
      chk("wkind", {1'b1, op[3], op[2], (k == 2) || op[3]}, reqInfo[35:32]);
      chk("wdata", 8'h5A, reqInfo[7:0]);
    end
    chk("accesses", 16'd8, 16'(memCount));
    cpuIdle = 1'b1;
    $display("Test memory finished");
  endtask
  task automatic tEnter;
    logic [15:0] w;
    int n0;
    rdMem(8'hE4, 16'hFF01, w);
    n0 = memCount;
    wrMem(8'hC4, 16'hFF01, w | 16'h0080);
    rdMem(8'hE4, 16'hFF01, w);
    chk("status", 16'h0080, w);
    chk("accesses", 16'(n0), 16'(memCount));
    cmd(8'h90);
    chk("bgActive", 1'b0, bgActive);
    ev(0);
    chk("bgActive", 1'b1, bgActive);
    chk("mapped", 1'b1, dbgMapped);
    chk("halt", 4'hA, periphHalt);
    rdMem(8'hE4, 16'hFF01, w);
    chk("status", 16'h00C0, w);
    $display("Test enter finished");
  endtask
  task automatic tFirmware;
    logic [15:0] w;
    logic [7:0] op;
    int n0;
    for (int k = 0; k < 6; k++) begin
      op = 8'h62 + 8'(k);
      cmd(op);
      i_host.recvWord(w);
      chk("fwRead", {op, 8'h5A}, w);
      i_host.sendByte(op - 8'h20);
      i_host.sendWord({op, 8'hC3});
      cyc(80);
      chk("fwOp", op - 8'h20, fwInfo[23:16]);
      chk("fwWdata", {op, 8'hC3}, fwInfo[15:0]);
    end
    n0 = resCount;
    cmd(8'h10);
    chk("bgActive", 1'b0, bgActive);
    ev(0);
    chk("bgActive", 1'b1, bgActive);
    cmd(8'h18);
    ev(1);
    chk("bgActive", 1'b1, bgActive);
    cmd(8'h08);
    chk("halt", 4'h0, periphHalt);
    chk("resumes", 16'(n0 + 3), 16'(resCount));
    ev(2);
    chk("bgActive", 1'b1, bgActive);
    cmd(8'h08);
    n0 = fwCount;
    cmd(8'h63);
    cmd(8'h77);
    chk("fwCount", 16'(n0), 16'(fwCount));
    $display("Test firmware finished");
  endtask
  task automatic tTimeout;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) i_host.bitTx(1'b1);
    cyc(600);
    rdMem(8'hE4, 16'hFF01, w);
    chk("status", 2'b10, w[7:6]);
    cyc(1);
    rstN = 1'b0;
    modeSpecialSc = 1'b1;
    cyc(2);
    rstN = 1'b1;
    cyc(6);
    chk("bgActive", 1'b1, bgActive);
    $display("Test timeout finished");
  endtask
  initial begin
    #1_500_000;
    miscompares++;
    end_of_test;
  end
  initial begin
    cyc(12);
    rstN = 1'b1;
    cyc(4);
    tGated();
    tHwMem();
    tEnter();
    tFirmware();
    tTimeout();
    end_of_test;
  end
endmodule
